// >>> mca_client.sv
// availability and response gating of the management client
`timescale 1ns/1ps
module mca_client
  import mca_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // power and straps
  input wire logic power_good_input_i,
  input wire logic [1:0] socket_select_straps_i,
  input wire logic warm_reset_i,
  input wire logic cpu_only_reset_i,
  // power states
  input wire logic [2:0] target_core_cstate_i,
  input wire logic [2:0] pkg_cstate_i,
  input wire logic [2:0] sleep_state_i,
  input wire logic resources_low_power_i,
  // boot and error status
  input wire logic service_processor_mode_i,
  input wire logic go_handshake_i,
  input wire logic catastrophic_error_pin_i,
  input wire logic err_in_power_control_unit_i,
  input wire logic data_not_ready_phase_i,
  // configuration
  input wire logic wake_on_request_bit_i,
  input wire logic filter_wr_i,
  input wire logic [15:0] filter_wdata_i,
  // requests
  input wire logic req_valid_i,
  input wire mca_cmd_t req_cmd_i,
  input wire logic [7:0] req_index_i,
  input wire logic req_retry_i,
  input wire logic [REQ_W-1:0] req_key_i,
  input wire logic [15:0] temp_sample_i,
  input wire logic temp_sample_valid_i,
  input wire logic op_done_i,
  // results
  output logic [7:0] client_addr_o,
  output logic addr_valid_o,
  output logic resp_valid_o,
  output mca_act_t resp_act_o,
  output logic [7:0] resp_cc_o,
  output logic op_start_o,
  output logic pkg_wake_c2_o,
  output logic [15:0] temp_o,
  output logic [15:0] filter_const_o,
  output logic ssp_active_o,
  output logic sem_held_o,
  output logic bus_idle_o
);
  // three-stage pin sync; second/third agree to accept
  logic [2:0] pg_s;
  logic [2:0] cat_s;
  logic pg;
  logic cat;
  logic pg_prev;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pg_s <= 3'h0;
      cat_s <= 3'h0;
      pg <= 1'b0;
      cat <= 1'b0;
      pg_prev <= 1'b0;
    end else begin
      pg_s <= {pg_s[1:0], power_good_input_i};
      cat_s <= {cat_s[1:0], catastrophic_error_pin_i};
      if (pg_s[1] == pg_s[2]) pg <= pg_s[2];
      if (cat_s[1] == cat_s[2]) cat <= cat_s[2];
      pg_prev <= pg;
    end
  end
  wire pg_rise = pg && !pg_prev;

  // strap capture survives warm reset; only power-good edge reloads it
  logic [1:0] sock;
  logic addr_valid;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sock <= 2'h0;
      addr_valid <= 1'b0;
    end else if (pg_rise) begin
      sock <= socket_select_straps_i;
      addr_valid <= 1'b1;
    end else if (!pg) begin
      addr_valid <= 1'b0;
    end
  end
  wire [7:0] next_addr = ADDR_BASE | {6'h00, sock};

  // warm reset: filter and address kept, rest back to defaults
  logic warm_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) warm_q <= 1'b0;
    else warm_q <= warm_reset_i;
  end
  wire warm = warm_reset_i || warm_q;

  logic [15:0] filter;
  logic [15:0] temp;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      filter <= FILTER_RESET;
      temp <= TEMP_RESET;
    end else begin
      if (filter_wr_i && !warm) filter <= filter_wdata_i;
      if (warm) temp <= TEMP_RESET;
      else if (temp_sample_valid_i && !data_not_ready_phase_i) temp <= temp_sample_i;
    end
  end

  // service mode latched until go
  logic service_processor_mode;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) service_processor_mode <= 1'b0;
    else if (warm) service_processor_mode <= 1'b0;
    else if (go_handshake_i) service_processor_mode <= 1'b0;
    else if (service_processor_mode_i) service_processor_mode <= 1'b1;
  end

  // command classes
  wire basic = (req_cmd_i == CMD_PING) || (req_cmd_i == CMD_DEVICE_INFO)
    || (req_cmd_i == CMD_TEMP_READ);
  wire pkgc = (req_cmd_i == CMD_PKG_CFG_READ) || (req_cmd_i == CMD_PKG_CFG_WRITE);
  wire local_cfg = (req_cmd_i == CMD_LOCAL_CFG_READ) || (req_cmd_i == CMD_LOCAL_CFG_WRITE);
  wire space = req_cmd_i == CMD_CFG_SPACE_READ;
  wire core = req_cmd_i == CMD_CORE_REG_READ;
  wire known = basic || pkgc || local_cfg || space || core;
  wire pcu_err = cat && err_in_power_control_unit_i;
  wire ssp_ok = (req_cmd_i == CMD_PING) || local_cfg
    || (req_cmd_i == CMD_PKG_CFG_READ && req_index_i == PKG_IDX0);
  wire s01 = (sleep_state_i == SSTATE_S0) || (sleep_state_i == SSTATE_S1);
  wire s0 = sleep_state_i == SSTATE_S0;
  wire core_deep = target_core_cstate_i >= CSTATE_C3;
  wire wake = wake_on_request_bit_i && (local_cfg || space) && resources_low_power_i;

  // sem interface
  mca_sem_if sem ();
  logic start_q;
  logic done_q;
  logic [7:0] done_cc_q;
  assign sem.req_valid = req_valid_i;
  assign sem.retry = req_retry_i;
  assign sem.req_key = req_key_i;
  assign sem.start = start_q;
  assign sem.done = done_q;
  assign sem.done_cc = done_cc_q;
  mca_retry_track u_track (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .warm_clr_i(warm),
    .sem(sem)
  );

  // decision, priority top to bottom
  mca_act_t next_act;
  logic [7:0] next_cc;
  always_comb begin
    next_act = ACT_SERVE;
    next_cc = CC_PASS;
    if (!known) begin
      next_act = ACT_CODE;
      next_cc = CC_UNSUPPORTED;
    end else if (sem.dup) begin
      next_act = ACT_REPLAY;
      next_cc = sem.held_cc;
    end else if (basic) begin
      next_act = ACT_SERVE;
    end else if (pcu_err) begin
      next_act = ACT_CODE;
      next_cc = CC_PCU_ERROR;
    end else if (service_processor_mode && !ssp_ok) begin
      next_act = ACT_CODE;
      next_cc = CC_RES_TIMEOUT;
    end else if (data_not_ready_phase_i || cpu_only_reset_i) begin
      // resources under reset answer as a timeout
      next_act = ACT_CODE;
      next_cc = CC_RES_TIMEOUT;
    end else if (sem.held) begin
      next_act = ACT_CODE;
      next_cc = CC_RES_TIMEOUT;
    end else if (pkgc) begin
      next_act = ACT_SERVE;
    end else if (cat && (core || space)) begin
      next_act = ACT_CODE;
      next_cc = CC_RES_TIMEOUT;
    end else if (core && (core_deep || !s0)) begin
      next_act = ACT_CODE;
      next_cc = CC_LOW_POWER;
    end else if ((local_cfg || space) && resources_low_power_i && !wake_on_request_bit_i) begin
      next_act = ACT_CODE;
      next_cc = CC_LOW_POWER;
    end else if ((space && !s0) || (local_cfg && !s01)) begin
      next_act = ACT_CODE;
      next_cc = CC_RES_TIMEOUT;
    end
  end
  wire go = req_valid_i && pg && !warm;
  wire next_start = go && next_act == ACT_SERVE && !basic;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      resp_valid_o <= 1'b0;
      resp_act_o <= ACT_SERVE;
      resp_cc_o <= 8'h00;
      op_start_o <= 1'b0;
      start_q <= 1'b0;
      done_q <= 1'b0;
      done_cc_q <= 8'h00;
      pkg_wake_c2_o <= 1'b0;
      bus_idle_o <= 1'b1;
    end else begin
      resp_valid_o <= go;
      resp_act_o <= next_act;
      resp_cc_o <= go ? next_cc : 8'h00;
      op_start_o <= next_start;
      start_q <= next_start;
      done_q <= op_done_i && !warm;
      done_cc_q <= CC_PASS;
      // raise the package only when the access would otherwise fail
      // a replay starts nothing, so it must not raise the package again
      pkg_wake_c2_o <= next_start && wake && (pkg_cstate_i > PKG_C2);
      bus_idle_o <= warm || !req_valid_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      client_addr_o <= ADDR_BASE;
      addr_valid_o <= 1'b0;
      temp_o <= TEMP_RESET;
      filter_const_o <= FILTER_RESET;
      ssp_active_o <= 1'b0;
      sem_held_o <= 1'b0;
    end else begin
      client_addr_o <= next_addr;
      addr_valid_o <= addr_valid;
      temp_o <= temp;
      filter_const_o <= filter;
      ssp_active_o <= service_processor_mode;
      sem_held_o <= sem.held;
    end
  end

  a_addr_strap: assert property (@(posedge clk_i) disable iff (!rstn_i)
    addr_valid_o |-> client_addr_o[7:2] == ADDR_BASE[7:2])
    else $error("client address outside strap range");
  a_core_deep: assert property (@(posedge clk_i) disable iff (!rstn_i)
    go && !sem.dup && core && !pcu_err && !service_processor_mode && !cat && !data_not_ready_phase_i
      && !cpu_only_reset_i && !sem.held && core_deep |=> resp_cc_o == CC_LOW_POWER)
    else $error("deep core read not answered 0x82");
  a_pcu_err: assert property (@(posedge clk_i) disable iff (!rstn_i)
    go && known && !basic && !sem.dup && pcu_err |=> resp_cc_o == CC_PCU_ERROR)
    else $error("power unit error not answered 0x91");
  a_basic_serve: assert property (@(posedge clk_i) disable iff (!rstn_i)
    go && basic && !sem.dup |=> resp_act_o == ACT_SERVE && resp_cc_o == CC_PASS)
    else $error("basic command not served");
  a_ssp_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    go && service_processor_mode && known && !ssp_ok && !basic && !sem.dup && !pcu_err
      |=> resp_cc_o == CC_RES_TIMEOUT)
    else $error("service mode let an unsupported command through");
  a_ssp_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
    service_processor_mode && !go_handshake_i && !warm |=> service_processor_mode)
    else $error("service mode left without go");
  a_warm_temp: assert property (@(posedge clk_i) disable iff (!rstn_i)
    warm_reset_i |=> ##1 temp_o == TEMP_RESET && $stable(client_addr_o))
    else $error("warm reset did not clear temperature");
  a_warm_abort: assert property (@(posedge clk_i) disable iff (!rstn_i)
    warm_reset_i |=> !resp_valid_o && bus_idle_o)
    else $error("response continued through reset");
  a_fail_bit7: assert property (@(posedge clk_i) disable iff (!rstn_i)
    resp_valid_o && resp_act_o == ACT_CODE |-> resp_cc_o[7])
    else $error("failing code without bit 7");
  a_wake_new_op: assert property (@(posedge clk_i) disable iff (!rstn_i)
    pkg_wake_c2_o |-> $past(next_start))
    else $error("package raised without a new access");
  a_unknown_cmd: assert property (@(posedge clk_i) disable iff (!rstn_i)
    go && !known |=> resp_cc_o == CC_UNSUPPORTED)
    else $error("unknown command not answered 0x90");
endmodule // mca_client

// >>> mca_client_test.sv
// self-checking bench for the management client availability block
`timescale 1ns/1ps
module mca_client_test;
  import mca_pkg::*;
  logic clk_i = 0, rstn_i = 0, pg = 0, warm = 0, cpu_rst = 0, lowp = 0, service_processor_mode = 0, go = 0;
  logic cat = 0, power_control_unit = 0, data_not_ready_phase = 0, wake = 0, fwr = 0, rv = 0, rty = 0, tsv = 0, slow = 0;
  logic [1:0] straps = 0;
  logic [2:0] ccs = 0, pcs = 0, ss = 0;
  logic [7:0] idx = 0, addr, cc;
  logic [15:0] fdat = 0, ts = 0, temp, filt, fv;
  logic [39:0] key = 0, k0;
  mca_cmd_t cmd = CMD_PING;
  mca_act_t act;
  logic done, addr_v, resp_v, start, wk, ssp_a, held, idle;
  logic [10:0] q[$];
  logic [10:0] ok;
  int fails = 0, checks_done = 0, wakes = 0, n;
  mca_cmd_t bl[7] = '{CMD_PING, CMD_DEVICE_INFO, CMD_TEMP_READ, CMD_PKG_CFG_READ,
    CMD_PKG_CFG_WRITE, CMD_LOCAL_CFG_READ, CMD_LOCAL_CFG_WRITE};

  always #2.5 clk_i = ~clk_i;

  mca_client dut (.clk_i(clk_i), .rstn_i(rstn_i), .power_good_input_i(pg),
    .socket_select_straps_i(straps), .warm_reset_i(warm), .cpu_only_reset_i(cpu_rst),
    .target_core_cstate_i(ccs), .pkg_cstate_i(pcs), .sleep_state_i(ss),
    .resources_low_power_i(lowp), .service_processor_mode_i(service_processor_mode), .go_handshake_i(go),
    .catastrophic_error_pin_i(cat), .err_in_power_control_unit_i(power_control_unit),
    .data_not_ready_phase_i(data_not_ready_phase), .wake_on_request_bit_i(wake), .filter_wr_i(fwr),
    .filter_wdata_i(fdat), .req_valid_i(rv), .req_cmd_i(cmd), .req_index_i(idx),
    .req_retry_i(rty), .req_key_i(key), .temp_sample_i(ts), .temp_sample_valid_i(tsv),
    .op_done_i(done), .client_addr_o(addr), .addr_valid_o(addr_v), .resp_valid_o(resp_v),
    .resp_act_o(act), .resp_cc_o(cc), .op_start_o(start), .pkg_wake_c2_o(wk),
    .temp_o(temp), .filter_const_o(filt), .ssp_active_o(ssp_a), .sem_held_o(held),
    .bus_idle_o(idle));

  mca_op_model partner (.clk_i(clk_i), .rstn_i(rstn_i), .op_start_i(start), .slow_i(slow),
    .op_done_o(done));

  function automatic logic [10:0] ex(input mca_act_t a, input logic [7:0] c);
    return {a, c, a == ACT_SERVE};
  endfunction

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held one full cycle, changed only at falling edges
  task automatic send(input mca_cmd_t c, input logic [7:0] i, input logic r,
    input logic [10:0] e);
    @(negedge clk_i);
    rv = 1;
    cmd = c;
    idx = i;
    rty = r;
    if (!r) key = {$urandom, i};
    // basic commands answer at once, no operation starts for them
    q.push_back({e[10:1], e[0] && !(c inside {CMD_PING, CMD_DEVICE_INFO, CMD_TEMP_READ})});
    @(negedge clk_i);
    rv = 0;
    rty = 0;
  endtask

  // fetch the pending result promptly, only a warm reset would free the semaphore otherwise
  task automatic go_cmd(input mca_cmd_t c, input logic [7:0] i, input logic [10:0] e);
    slow = 1'($urandom);
    send(c, i, 0, e);
    repeat (25) @(negedge clk_i);
    if (held === 1'b1) send(c, i, 1, ex(ACT_REPLAY, CC_PASS));
  endtask

  always @(negedge clk_i) begin
    if (resp_v === 1'b1) begin
      if (q.size() == 0) chk(resp_v, 0);
      else chk({act, cc, start}, q.pop_front());
    end
  end

  always @(negedge clk_i) begin
    if (wk === 1'b1) wakes++;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    finish_test();
  end

  initial begin
    void'($urandom(87));
    ok = ex(ACT_SERVE, CC_PASS);
    repeat (3) @(negedge clk_i);
    rstn_i = 1;
    for (int s = 0; s < 4; s++) begin
      pg = 0;
      straps = s[1:0];
      repeat (3) @(negedge clk_i);
      pg = 1;
      repeat (10) @(negedge clk_i);
      straps = ~straps;
      repeat (3) @(negedge clk_i);
      chk({addr_v, addr}, {1'b1, ADDR_BASE + 8'(s)});
    end
    $display("test straps done");
    for (int k = 0; k < 8; k++) begin
      ccs = k[2:0];
      pcs = 3'($urandom_range(0, 6));
      for (int j = 0; j < 5; j++) go_cmd(bl[j], 0, ok);
      go_cmd(CMD_CORE_REG_READ, 0, k >= 3 ? ex(ACT_CODE, CC_LOW_POWER) : ok);
    end
    $display("test cstates done");
    ccs = 0;
    lowp = 1;
    pcs = 3'h6;
    for (int w = 0; w < 2; w++) begin
      wake = w[0];
      n = wakes;
      go_cmd(CMD_LOCAL_CFG_READ, 0, w ? ok : ex(ACT_CODE, CC_LOW_POWER));
      go_cmd(CMD_LOCAL_CFG_WRITE, 0, w ? ok : ex(ACT_CODE, CC_LOW_POWER));
      go_cmd(CMD_CFG_SPACE_READ, 0, w ? ok : ex(ACT_CODE, CC_LOW_POWER));
      chk(wakes - n, w ? 3 : 0);
    end
    lowp = 0;
    wake = 0;
    $display("test low power done");
    ss = SSTATE_S1;
    for (int j = 0; j < 7; j++) go_cmd(bl[j], 0, ok);
    ss = SSTATE_S0;
    go_cmd(CMD_CFG_SPACE_READ, 0, ok);
    go_cmd(CMD_CORE_REG_READ, 0, ok);
    cpu_rst = 1;
    for (int j = 0; j < 3; j++) go_cmd(CMD_PKG_CFG_READ, PKG_IDX0, ex(ACT_CODE, CC_RES_TIMEOUT));
    for (int j = 0; j < 3; j++) go_cmd(bl[j], 0, ok);
    go_cmd(CMD_LOCAL_CFG_READ, 0, ex(ACT_CODE, CC_RES_TIMEOUT));
    cpu_rst = 0;
    $display("test sleep and cpu reset done");
    @(negedge clk_i);
    service_processor_mode = 1;
    @(negedge clk_i);
    service_processor_mode = 0;
    go_cmd(CMD_PING, 0, ok);
    go_cmd(CMD_LOCAL_CFG_READ, 0, ok);
    go_cmd(CMD_LOCAL_CFG_WRITE, 0, ok);
    go_cmd(CMD_PKG_CFG_READ, PKG_IDX0, ok);
    go_cmd(CMD_PKG_CFG_READ, 8'h01, ex(ACT_CODE, CC_RES_TIMEOUT));
    go_cmd(CMD_CORE_REG_READ, 0, ex(ACT_CODE, CC_RES_TIMEOUT));
    chk(ssp_a, 1);
    @(negedge clk_i);
    go = 1;
    @(negedge clk_i);
    go = 0;
    repeat (2) @(negedge clk_i);
    chk(ssp_a, 0);
    $display("test service mode done");
    cat = 1;
    power_control_unit = 1;
    repeat (5) @(negedge clk_i);
    for (int j = 0; j < 3; j++) go_cmd(bl[j], 0, ok);
    go_cmd(CMD_PKG_CFG_READ, PKG_IDX0, ex(ACT_CODE, CC_PCU_ERROR));
    go_cmd(CMD_LOCAL_CFG_READ, 0, ex(ACT_CODE, CC_PCU_ERROR));
    power_control_unit = 0;
    go_cmd(CMD_PKG_CFG_READ, PKG_IDX0, ok);
    go_cmd(CMD_PKG_CFG_WRITE, 0, ok);
    cat = 0;
    repeat (5) @(negedge clk_i);
    go_cmd(CMD_UNKNOWN, 0, ex(ACT_CODE, CC_UNSUPPORTED));
    $display("test errors done");
    slow = 1;
    send(CMD_CORE_REG_READ, 0, 0, ok);
    k0 = key;
    send(CMD_LOCAL_CFG_READ, 0, 0, ex(ACT_CODE, CC_RES_TIMEOUT));
    repeat (25) @(negedge clk_i);
    chk(held, 1);
    key = k0;
    send(CMD_CORE_REG_READ, 0, 1, ex(ACT_REPLAY, CC_PASS));
    // the held flag output trails the release by one register stage
    @(negedge clk_i);
    chk(held, 0);
    $display("test retry done");
    @(negedge clk_i);
    ts = 16'($urandom_range(1, 65535));
    tsv = 1;
    fwr = 1;
    fdat = 16'($urandom);
    fv = fdat;
    @(negedge clk_i);
    tsv = 0;
    fwr = 0;
    @(negedge clk_i);
    chk({temp, filt}, {ts, fv});
    warm = 1;
    rv = 1;
    cmd = CMD_PING;
    @(negedge clk_i);
    rv = 0;
    warm = 0;
    repeat (3) @(negedge clk_i);
    chk({temp, filt, addr, idle}, {TEMP_RESET, fv, 8'h33, 1'b1});
    rstn_i = 0;
    @(negedge clk_i);
    chk({addr_v, addr, temp}, {1'b0, ADDR_BASE, TEMP_RESET});
    rstn_i = 1;
    $display("test resets done");
    repeat (5) @(negedge clk_i);
    chk(q.size(), 0);
    finish_test();
  end
endmodule // mca_client_test

// >>> mca_op_model.sv
// far-side model that finishes started operations after a short or long delay
`timescale 1ns/1ps
module mca_op_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // control
  input wire logic op_start_i,
  input wire logic slow_i,
  // completion
  output logic op_done_o
);
  logic [4:0] cnt;
  logic busy;
  // done comes late on purpose when slow, so the held semaphore is really exercised
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 5'h00;
      busy <= 1'b0;
      op_done_o <= 1'b0;
    end else begin
      op_done_o <= 1'b0;
      if (op_start_i) begin
        cnt <= slow_i ? 5'h14 : 5'h01;
        busy <= 1'b1;
      end else if (busy && cnt == 5'h00) begin
        busy <= 1'b0;
        op_done_o <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
endmodule // mca_op_model

// >>> mca_pkg.sv
// shared constants and types for the management client availability block
package mca_pkg;
  localparam logic [7:0] ADDR_BASE = 8'h30;
  localparam logic [7:0] CC_PASS = 8'h40;
  localparam logic [7:0] CC_RES_TIMEOUT = 8'h81;
  localparam logic [7:0] CC_LOW_POWER = 8'h82;
  localparam logic [7:0] CC_UNSUPPORTED = 8'h90;
  localparam logic [7:0] CC_PCU_ERROR = 8'h91;
  localparam logic [15:0] TEMP_RESET = 16'h0000;
  localparam logic [2:0] CSTATE_C3 = 3'h3;
  localparam logic [2:0] PKG_C2 = 3'h2;
  localparam logic [2:0] SSTATE_S0 = 3'h0;
  localparam logic [2:0] SSTATE_S1 = 3'h1;
  localparam logic [7:0] PKG_IDX0 = 8'h00;
  localparam logic [15:0] FILTER_RESET = 16'h0000;
  localparam int REQ_W = 40;
  typedef enum logic [3:0] {
    CMD_PING, CMD_DEVICE_INFO, CMD_TEMP_READ, CMD_PKG_CFG_READ, CMD_PKG_CFG_WRITE,
    CMD_CORE_REG_READ, CMD_LOCAL_CFG_READ, CMD_LOCAL_CFG_WRITE, CMD_CFG_SPACE_READ,
    CMD_UNKNOWN
  } mca_cmd_t;
  typedef enum logic [1:0] {
    ACT_SERVE, ACT_CODE, ACT_ABORT, ACT_REPLAY
  } mca_act_t;
endpackage

// >>> mca_retry_track.sv
// retry duplicate detector and held semaphore
`timescale 1ns/1ps
module mca_retry_track
  import mca_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic warm_clr_i,
  // link to owner
  mca_sem_if.tracker sem
);
  logic [REQ_W-1:0] last_key;
  logic last_valid;
  logic held;
  logic [7:0] held_cc;
  logic pend;
  wire match = last_valid && (sem.req_key == last_key);
  assign sem.dup = sem.req_valid && sem.retry && match;
  assign sem.held = held;
  assign sem.held_cc = held_cc;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      last_key <= '0;
      last_valid <= 1'b0;
      held <= 1'b0;
      held_cc <= 8'h00;
      pend <= 1'b0;
    end else if (warm_clr_i) begin
      last_valid <= 1'b0;
      held <= 1'b0;
      pend <= 1'b0;
    end else begin
      if (sem.start) begin
        last_key <= sem.req_key;
        last_valid <= 1'b1;
        held <= 1'b1;
        pend <= 1'b1;
      end
      if (sem.done && pend) begin
        held_cc <= sem.done_cc;
        pend <= 1'b0;
      end
      // a retry that collects the result or a warm reset frees it; no timeout
      if (sem.dup && !pend) begin
        held <= 1'b0;
      end
    end
  end
  a_sem_held_free: assert property (@(posedge clk_i) disable iff (!rstn_i)
    held && !sem.dup && !sem.start && !warm_clr_i |=> held)
    else $error("semaphore dropped without a retry");
endmodule // mca_retry_track

// >>> mca_sem_if.sv
// interface between the decision logic and the retry tracker
`timescale 1ns/1ps
interface mca_sem_if;
  logic req_valid;
  logic retry;
  logic [39:0] req_key;
  logic start;
  logic done;
  logic [7:0] done_cc;
  logic dup;
  logic held;
  logic [7:0] held_cc;
  modport owner (output req_valid, retry, req_key, start, done, done_cc,
    input dup, held, held_cc);
  modport tracker (input req_valid, retry, req_key, start, done, done_cc,
    output dup, held, held_cc);
endinterface
